// [hw/week_alarm_timer_map.vh]
// Address map, field positions and reset values of the week alarm timer core.
// Assumes inclusion by the timer core and its counter leaves only.
`ifndef WEEK_ALARM_TIMER_MAP_VH
`define WEEK_ALARM_TIMER_MAP_VH

// Block base in the 32-bit internal address space
`define WAT_BASE_ADDR 32'h0000cc80
`define WAT_BLOCK_MASK 32'hffffffe0

// Register offsets
`define WAT_OFF_TIMER_CONTROL 5'h00
`define WAT_OFF_SECONDS_COUNT 5'h04
`define WAT_OFF_ALARM_MATCH_VALUE 5'h08
`define WAT_OFF_PRESCALER_READBACK 5'h0c
`define WAT_OFF_FRACTION_TICK_SELECT 5'h10
`define WAT_OFF_SHORT_ALARM_CONTROL 5'h14
`define WAT_OFF_SHORT_ALARM_COUNT 5'h18

// Timer control fields
`define WAT_CTL_COUNTING_ENABLE_BIT 0
`define WAT_CTL_BATTERY_OUTPUT_BIT 5
`define WAT_CTL_WAKE_OUTPUT_ENABLE_BIT 6

// Widths
`define WAT_SECONDS_WIDTH 28
`define WAT_PRESCALER_WIDTH 15

// Reset values
`define WAT_RST_TIMER_CONTROL 32'h00000000
`define WAT_RST_SECONDS_COUNT 28'h0000000
`define WAT_RST_ALARM_MATCH_VALUE 28'h0ffffff
`define WAT_RST_PRESCALER 15'h0000

// Prescaler wraps from this value to zero once a second
`define WAT_PRESCALER_MAX 15'h7fff

`endif

// [hw/prescaler_15.v]
// Fifteen-bit prescaler stepped by edges of the low-speed timebase.
// Assumes the edge strobe is one clk cycle wide and synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "week_alarm_timer_map.vh"

module prescaler_15
#(
  parameter WIDTH = `WAT_PRESCALER_WIDTH
)
(
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Control
  input wire countEnable,
  input wire timebaseEdge,
  // Status
  output reg [WIDTH-1:0] count_reg,
  output reg wrapTick_reg
);

  reg [WIDTH-1:0] count_next;
  reg wrapTick_next;

  always @*
  begin
    count_next = count_reg;
    wrapTick_next = 1'b0;
    if (!countEnable)
    begin
      // Held at zero so nothing toggles while stopped
      count_next = {WIDTH{1'b0}}; // see RL3
    end
    else if (timebaseEdge)
    begin
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1}; // see RL13
      wrapTick_next = (count_reg == `WAT_PRESCALER_MAX); // see RL13
    end
  end

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      count_reg <= `WAT_RST_PRESCALER;
      wrapTick_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      wrapTick_reg <= wrapTick_next;
    end
  end

endmodule // prescaler_15

`default_nettype wire

// [hw/seconds_counter_28.v]
// Twenty-eight-bit seconds counter with a firmware load port.
// Assumes the tick strobe is one clk cycle wide, once per second.
`timescale 1ns/1ps
`default_nettype none
`include "week_alarm_timer_map.vh"

module seconds_counter_28
#(
  parameter WIDTH = `WAT_SECONDS_WIDTH
)
(
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Control
  input wire countEnable,
  input wire secondTick,
  input wire load,
  input wire [WIDTH-1:0] loadValue,
  // Status
  output reg [WIDTH-1:0] count_reg
);

  reg [WIDTH-1:0] count_next;

  always @*
  begin
    count_next = count_reg;
    if (load)
    begin
      // Load wins over a coinciding tick; firmware sees its own value
      count_next = loadValue; // see RL9
    end
    else if (countEnable && secondTick)
    begin
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1}; // see RL7
    end
    // Otherwise held, resuming from here on re-enable (see RL2)
  end

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      count_reg <= `WAT_RST_SECONDS_COUNT;
    end
    else
    begin
      count_reg <= count_next;
    end
  end

endmodule // seconds_counter_28

`default_nettype wire

// [hw/week_alarm_timer_core.v]
// Week alarm timer core: control, seconds count, alarm compare, prescaler.
// Assumes a single-cycle register port in the clk domain and a low-speed
// timebase input that is synchronous to clk.
//
// Operation
// RL1: Enable bit runs seconds counter and prescaler.
// RL2: Disabled counter holds value, resumes on enable.
// RL3: Disabled prescaler forced zero, lowest power.
// RL4: Wake enable clear disables and resets event.
// RL5: Wake enable gates alarm decode toward VCI.
// RL6: Battery output follows its control bit.
// RL7: Seconds counter increments once per second.
// RL8: Seconds write may take one second.
// RL9: Live reads; accesses work regardless of enable.
// RL10: Alarm asserted while count at least compare.
// RL11: Prescaler readback is read-only live count.
// RL12: Registers decoded at base plus offset.
// RL13: Prescaler wrap to zero gives 1 Hz.
// RL14: Writes complete within two timebase cycles.
// RL15: Reserved bits read zero, writes ignored.
`timescale 1ns/1ps
`default_nettype none
`include "week_alarm_timer_map.vh"

module week_alarm_timer_core
#(
  parameter SEC_WIDTH = `WAT_SECONDS_WIDTH,
  parameter DIV_WIDTH = `WAT_PRESCALER_WIDTH
)
(
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port
  input wire [31:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [31:0] regWriteData,
  output reg [31:0] regReadData_reg,
  output reg regReadValid_reg,
  output reg regWriteDone_reg,
  // Timebase
  input wire lowSpeedTimebaseClock,
  // Events and pins
  output reg alarmInterrupt_reg,
  output reg powerUpEvent_reg,
  output reg vciWakeDecodeEnable_reg,
  output reg batteryGeneralOutput_reg,
  output reg lowPowerState_reg
);

  // Register selects
  localparam SEL_NONE = 3'h0;
  localparam SEL_CONTROL = 3'h1;
  localparam SEL_SECONDS = 3'h2;
  localparam SEL_MATCH = 3'h3;
  localparam SEL_PRESCALER = 3'h4;
  localparam SEL_LOCATED = 3'h5;

  // Control word after power-on reset; reserved bits stay zero
  localparam [31:0] CTL_RESET = `WAT_RST_TIMER_CONTROL;

  // Address decode shared by the read and write paths
  function [2:0] decodeSel;
    input [31:0] addr;
    begin
      decodeSel = SEL_NONE;
      if ((addr & `WAT_BLOCK_MASK) == `WAT_BASE_ADDR) // see RL12
      begin
        case (addr[4:0])
          `WAT_OFF_TIMER_CONTROL: decodeSel = SEL_CONTROL;
          `WAT_OFF_SECONDS_COUNT: decodeSel = SEL_SECONDS;
          `WAT_OFF_ALARM_MATCH_VALUE: decodeSel = SEL_MATCH;
          `WAT_OFF_PRESCALER_READBACK: decodeSel = SEL_PRESCALER;
          `WAT_OFF_FRACTION_TICK_SELECT: decodeSel = SEL_LOCATED;
          `WAT_OFF_SHORT_ALARM_CONTROL: decodeSel = SEL_LOCATED;
          `WAT_OFF_SHORT_ALARM_COUNT: decodeSel = SEL_LOCATED;
          default: decodeSel = SEL_NONE;
        endcase
      end
    end
  endfunction

  // Control word as read back; reserved positions always zero
  function [31:0] packControl;
    input countBit;
    input outputBit;
    input wakeBit;
    begin
      packControl = 32'h00000000; // see RL15
      packControl[`WAT_CTL_COUNTING_ENABLE_BIT] = countBit;
      packControl[`WAT_CTL_BATTERY_OUTPUT_BIT] = outputBit;
      packControl[`WAT_CTL_WAKE_OUTPUT_ENABLE_BIT] = wakeBit;
    end
  endfunction

  // Control fields
  reg countingEnable_reg;
  reg countingEnable_next;
  reg wakeEventOutputEnable_reg;
  reg wakeEventOutputEnable_next;
  reg batteryGeneralOutputCtl_reg;
  reg batteryGeneralOutputCtl_next;

  // Compare value
  reg [SEC_WIDTH-1:0] alarmMatchValue_reg;
  reg [SEC_WIDTH-1:0] alarmMatchValue_next;

  // Timebase edge detection
  reg timebasePrev_reg;
  wire timebaseEdge;

  // Counter leaves
  wire [DIV_WIDTH-1:0] prescalerCount;
  wire secondTick;
  wire [SEC_WIDTH-1:0] secondsCount;

  // Access decode
  wire [2:0] writeSel;
  wire [2:0] readSel;
  wire writeHit;
  wire readHit;
  wire secondsLoad;

  // Derived alarm level
  wire countReachedMatch;

  // Next values of the output flops
  reg [31:0] regReadData_next;
  reg regReadValid_next;
  reg regWriteDone_next;
  reg alarmInterrupt_next;
  reg powerUpEvent_next;
  reg vciWakeDecodeEnable_next;
  reg batteryGeneralOutput_next;
  reg lowPowerState_next;

  assign writeSel = decodeSel(regAddr);
  // One decoder serves both directions; a read and a write may share a cycle
  assign readSel = writeSel;
  assign writeHit = regWrite && (writeSel != SEL_NONE);
  assign readHit = regRead && (readSel != SEL_NONE);

  // Writes land on the next clk edge, well inside two timebase cycles
  assign secondsLoad = regWrite && (writeSel == SEL_SECONDS); // see RL14

  // Rising edge of the timebase; input is synchronous to clk
  // A high level at reset release looks like an edge; counting is off then
  assign timebaseEdge = lowSpeedTimebaseClock && !timebasePrev_reg;

  // Unsigned compare keeps the alarm up after the count passes the match
  assign countReachedMatch = (secondsCount >= alarmMatchValue_reg); // see RL10

  prescaler_15
  #(
    .WIDTH(DIV_WIDTH)
  )
  i_prescaler_15
  (
    .clk(clk),
    .nrst(nrst),
    .countEnable(countingEnable_reg), // see RL1
    .timebaseEdge(timebaseEdge),
    .count_reg(prescalerCount),
    .wrapTick_reg(secondTick)
  );

  seconds_counter_28
  #(
    .WIDTH(SEC_WIDTH)
  )
  i_seconds_counter_28
  (
    .clk(clk),
    .nrst(nrst),
    .countEnable(countingEnable_reg), // see RL1
    .secondTick(secondTick),
    .load(secondsLoad), // see RL8
    .loadValue(regWriteData[SEC_WIDTH-1:0]),
    .count_reg(secondsCount)
  );

  // Register writes
  always @*
  begin
    countingEnable_next = countingEnable_reg;
    wakeEventOutputEnable_next = wakeEventOutputEnable_reg;
    batteryGeneralOutputCtl_next = batteryGeneralOutputCtl_reg;
    alarmMatchValue_next = alarmMatchValue_reg;
    // Unmapped writes still get their done pulse but change nothing
    if (writeHit)
    begin
      case (writeSel)
        SEL_CONTROL:
        begin
          // Only the three defined bits are stored
          countingEnable_next = regWriteData[`WAT_CTL_COUNTING_ENABLE_BIT]; // see RL15
          wakeEventOutputEnable_next = regWriteData[`WAT_CTL_WAKE_OUTPUT_ENABLE_BIT];
          batteryGeneralOutputCtl_next = regWriteData[`WAT_CTL_BATTERY_OUTPUT_BIT];
        end
        SEL_MATCH:
        begin
          // Accepted whatever the enable state
          alarmMatchValue_next = regWriteData[SEC_WIDTH-1:0]; // see RL9
        end
        default:
        begin
          // Prescaler readback is read-only; located registers ignore writes
          alarmMatchValue_next = alarmMatchValue_reg; // see RL11
        end
      endcase
    end
  end

  // Read path
  always @*
  begin
    regReadData_next = 32'h00000000;
    regReadValid_next = regRead;
    regWriteDone_next = regWrite;
    if (readHit)
    begin
      case (readSel)
        SEL_CONTROL:
        begin
          regReadData_next = packControl(countingEnable_reg, batteryGeneralOutputCtl_reg,
            wakeEventOutputEnable_reg);
        end
        SEL_SECONDS:
        begin
          // Live count, upper bits zero
          regReadData_next[SEC_WIDTH-1:0] = secondsCount; // see RL9
        end
        SEL_MATCH:
        begin
          regReadData_next[SEC_WIDTH-1:0] = alarmMatchValue_reg; // see RL15
        end
        SEL_PRESCALER:
        begin
          // Upper bits zero; the count is live, not latched
          regReadData_next[DIV_WIDTH-1:0] = prescalerCount; // see RL11
        end
        default:
        begin
          // Located-only registers have no behaviour here and read zero
          regReadData_next = 32'h00000000;
        end
      endcase
    end
  end

  // Pin and event outputs, one cycle behind their sources
  always @*
  begin
    alarmInterrupt_next = countReachedMatch; // see RL10
    // Clear enable holds the event output in reset
    powerUpEvent_next = wakeEventOutputEnable_reg && countReachedMatch; // see RL4
    vciWakeDecodeEnable_next = wakeEventOutputEnable_reg; // see RL5
    batteryGeneralOutput_next = batteryGeneralOutputCtl_reg; // see RL6
    lowPowerState_next = !countingEnable_reg; // see RL3
  end

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      countingEnable_reg <= CTL_RESET[`WAT_CTL_COUNTING_ENABLE_BIT];
      wakeEventOutputEnable_reg <= CTL_RESET[`WAT_CTL_WAKE_OUTPUT_ENABLE_BIT];
      batteryGeneralOutputCtl_reg <= CTL_RESET[`WAT_CTL_BATTERY_OUTPUT_BIT];
      alarmMatchValue_reg <= `WAT_RST_ALARM_MATCH_VALUE;
      timebasePrev_reg <= 1'b0;
      regReadData_reg <= 32'h00000000;
      regReadValid_reg <= 1'b0;
      regWriteDone_reg <= 1'b0;
      alarmInterrupt_reg <= 1'b0;
      powerUpEvent_reg <= 1'b0;
      vciWakeDecodeEnable_reg <= 1'b0;
      batteryGeneralOutput_reg <= 1'b0;
      // Counting starts stopped, hence the low-power state
      lowPowerState_reg <= 1'b1;
    end
    else
    begin
      countingEnable_reg <= countingEnable_next;
      wakeEventOutputEnable_reg <= wakeEventOutputEnable_next;
      batteryGeneralOutputCtl_reg <= batteryGeneralOutputCtl_next;
      alarmMatchValue_reg <= alarmMatchValue_next;
      timebasePrev_reg <= lowSpeedTimebaseClock;
      regReadData_reg <= regReadData_next;
      regReadValid_reg <= regReadValid_next;
      regWriteDone_reg <= regWriteDone_next;
      alarmInterrupt_reg <= alarmInterrupt_next;
      powerUpEvent_reg <= powerUpEvent_next;
      vciWakeDecodeEnable_reg <= vciWakeDecodeEnable_next;
      batteryGeneralOutput_reg <= batteryGeneralOutput_next;
      lowPowerState_reg <= lowPowerState_next;
    end
  end

endmodule // week_alarm_timer_core

`default_nettype wire

// [test/week_alarm_timer_props.sv]
// Port checker of the week alarm timer core.
// Assumes the core's one-cycle register port and registered event outputs.
`timescale 1ns/1ps
`default_nettype none

module week_alarm_timer_props
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [31:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regWriteData,
  input wire logic [31:0] regReadData_reg,
  input wire logic regReadValid_reg,
  input wire logic regWriteDone_reg,
  // Events and pins
  input wire logic alarmInterrupt_reg,
  input wire logic powerUpEvent_reg,
  input wire logic vciWakeDecodeEnable_reg,
  input wire logic batteryGeneralOutput_reg,
  input wire logic lowPowerState_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  AST_WR_DONE: assert property (regWrite |=> regWriteDone_reg)
    else $error("write not acknowledged");
  AST_RD_VALID: assert property (regRead |=> regReadValid_reg)
    else $error("read not answered");
  AST_RD_IDLE: assert property (!regReadValid_reg |-> regReadData_reg == 32'h0)
    else $error("read data without valid");
  AST_UNMAPPED: assert property (regRead && !(regAddr inside
    {32'h0000cc80, 32'h0000cc84, 32'h0000cc88, 32'h0000cc8c}) |=> regReadData_reg == 32'h0)
    else $error("unmapped read not zero");
  AST_CTL_RSVD: assert property (regRead && regAddr == 32'h0000cc80
    |=> (regReadData_reg & 32'hffffff9e) == 32'h0) else $error("control reserved bits set");
  AST_DIV_RSVD: assert property (regRead && regAddr == 32'h0000cc8c
    |=> regReadData_reg[31:15] == 17'h0) else $error("prescaler upper bits set");
  AST_DIV_STOP: assert property (regRead && regAddr == 32'h0000cc8c && lowPowerState_reg
    |=> regReadData_reg == 32'h0) else $error("prescaler not held at zero");
  AST_BATT_OUT: assert property (regWrite && regAddr == 32'h0000cc80
    |-> ##2 batteryGeneralOutput_reg == $past(regWriteData[5], 2))
    else $error("battery output wrong");
  AST_LOWPWR: assert property (regWrite && regAddr == 32'h0000cc80
    |-> ##2 lowPowerState_reg == !$past(regWriteData[0], 2)) else $error("power state wrong");
  AST_VCI: assert property (regWrite && regAddr == 32'h0000cc80
    |-> ##2 vciWakeDecodeEnable_reg == $past(regWriteData[6], 2)) else $error("decode wrong");
  AST_WAKE: assert property (powerUpEvent_reg |-> alarmInterrupt_reg && vciWakeDecodeEnable_reg)
    else $error("wake event without cause");

  // Main scenarios reached
  cover property (powerUpEvent_reg);
  cover property (alarmInterrupt_reg && !powerUpEvent_reg);
  cover property ($rose(alarmInterrupt_reg));
endmodule // week_alarm_timer_props

bind week_alarm_timer_core week_alarm_timer_props i_week_alarm_timer_props (.clk, .nrst,
  .regAddr, .regWrite, .regRead, .regWriteData, .regReadData_reg, .regReadValid_reg,
  .regWriteDone_reg, .alarmInterrupt_reg, .powerUpEvent_reg, .vciWakeDecodeEnable_reg,
  .batteryGeneralOutput_reg, .lowPowerState_reg);
`default_nettype wire

// [test/tb_week_alarm_timer_core.sv]
// Self-checking bench of the week alarm timer core.
// Assumes a synchronous timebase; the bench pulses it, one edge per two clk.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end

module tb_week_alarm_timer_core;
  logic clk = 0, nrst = 0, regWrite = 0, regRead = 0, tbase = 0;
  logic [31:0] regAddr = 0, regWriteData = 0, rdData, rnd;
  logic rdValid, wrDone, alarm, wake, vci, battOut, lowPwr;
  logic [27:0] secs, m;
  int n_mismatch = 0, n_compared = 0, n;

  week_alarm_timer_core i_week_alarm_timer_core (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData),
    .regReadData_reg(rdData), .regReadValid_reg(rdValid), .regWriteDone_reg(wrDone),
    .lowSpeedTimebaseClock(tbase), .alarmInterrupt_reg(alarm), .powerUpEvent_reg(wake),
    .vciWakeDecodeEnable_reg(vci), .batteryGeneralOutput_reg(battOut),
    .lowPowerState_reg(lowPwr));

  function automatic logic [31:0] nextRnd(input logic [31:0] s);
    nextRnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic ge(input logic [27:0] s, input logic [27:0] c);
    ge = s >= c;
  endfunction

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(negedge clk);
    `CHK(wrDone, 1'b1)
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    `CHK(rdValid, 1'b1)
    `CHK(rdData, e)
  endtask

  // Expected alarm, wake, decode, battery_general_output, low power
  task automatic pins(input logic a, input logic p, input logic v, input logic b, input logic l);
    @(posedge clk);
    @(negedge clk);
    `CHK({alarm, wake, vci, battOut, lowPwr}, {a, p, v, b, l})
  endtask

  // Timebase high and low one clk each, the fastest the core allows
  task automatic pulses(input int k);
    repeat (k)
    begin
      @(posedge clk) tbase <= 1'b1;
      @(posedge clk) tbase <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask

  task tally_and_finish;
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // About 66k clk needed; one second of timebase dominates
  initial
  begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end

  initial
  begin
    rnd = 32'h000146cb;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd(32'h0000cc80 + 32'(4 * i), (i == 2) ? 32'h00ffffff : 32'h0);
    pins(0, 0, 0, 0, 1);
    rd(32'h0000cca0, 32'h0);
    rd(32'h00000c80, 32'h0);
    wr(32'h0000cc8c, 32'h00007fff);
    rd(32'h0000cc8c, 32'h0);
    wr(32'h0000cc80, 32'hffffffff);
    rd(32'h0000cc80, 32'h00000061);
    pins(0, 0, 1, 1, 0);
    rnd = nextRnd(rnd);
    secs = {1'b0, rnd[26:0]} + 28'h1;
    wr(32'h0000cc84, {4'hf, secs});
    rd(32'h0000cc84, {4'h0, secs});
    for (int k = 0; k < 3; k++)
    begin
      m = secs + 28'(k) - 28'h1;
      wr(32'h0000cc88, {4'h0, m});
      pins(ge(secs, m), ge(secs, m), 1, 1, 0);
    end
    rnd = nextRnd(rnd);
    n = 1 + int'(rnd[7:0]);
    pulses(n);
    rd(32'h0000cc8c, 32'(n));
    pulses(32768 - n);
    rd(32'h0000cc8c, 32'h0);
    rd(32'h0000cc84, {4'h0, secs + 28'h1});
    pins(1, 1, 1, 1, 0);
    wr(32'h0000cc80, 32'h00000020);
    pulses(5);
    rd(32'h0000cc8c, 32'h0);
    rd(32'h0000cc84, {4'h0, secs + 28'h1});
    pins(1, 0, 0, 1, 1);
    wr(32'h0000cc84, {4'h0, secs + 28'h2});
    rd(32'h0000cc84, {4'h0, secs + 28'h2});
    wr(32'h0000cc80, 32'h00000001);
    pulses(3);
    rd(32'h0000cc8c, 32'h3);
    rd(32'h0000cc84, {4'h0, secs + 28'h2});
    pins(1, 0, 0, 0, 0);
    tally_and_finish;
  end
endmodule // tb_week_alarm_timer_core
`default_nettype wire
